// ==== core/lds_pkg.sv ====
// Purpose: Shared constants for the line driver serial control link.
// Assumes: 50 MHz system clock on both ends.
// Notes:   Word layout, timing figures and host register map live here.
package lds_pkg;
  // Word geometry
  localparam int unsigned WORD_BITS  = 12;           // Bits per word
  localparam int unsigned WORD_CYCLES = 13;          // Clock cycles per word
  localparam logic [3:0]  BIT_CNT_W  = 4'hc;         // Count at full word
  localparam logic [3:0]  CYC_LAST   = 4'hd;         // Cycles incl. trailer
  // Bit positions inside a word
  localparam int unsigned POS_START_HI = 0;          // Must be high
  localparam int unsigned POS_START_LO = 1;          // Must be low
  localparam int unsigned POS_SEL_CH1  = 2;          // Load channel one
  localparam int unsigned POS_SEL_CH2  = 3;          // Load channel two
  localparam int unsigned POS_SET_LO   = 4;          // First settings bit
  localparam int unsigned POS_PARITY   = 10;         // Odd parity bit
  localparam int unsigned POS_STOP     = 11;         // Must be high
  // Settings layout (6 bits, word bits 4..9)
  localparam int unsigned SET_W        = 6;          // Settings width
  localparam int unsigned SET_DRV      = 0;          // Driver on bit
  localparam int unsigned SET_ARM      = 1;          // Boost arm bit
  localparam logic [5:0]  SET_RST      = 6'h00;      // Disabled state
  localparam logic [11:0] WORD_ALL_ONE = 12'hfff;    // Reset-equivalent
  localparam logic [11:0] WORD_RST     = 12'h000;    // Shift reg clear
  // Timing at 50 MHz
  localparam int unsigned CLK_NS       = 20;         // System clock period
  localparam int unsigned HALF_NS      = 460;        // Half link period
  localparam int unsigned HALF_CYC     = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_HOLD_NS  = 400;        // Reset hold time
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_REL_NS   = 200;        // Release to first bit
  localparam int unsigned RST_REL_CYC  = (RST_REL_NS + CLK_NS - 1) / CLK_NS;
  // Host command register map
  localparam logic [3:0]  ADDR_CMD     = 4'h0;       // Write: send word
  localparam logic [3:0]  ADDR_RESET   = 4'h1;       // Write: pulse reset
  localparam logic [3:0]  ADDR_STATUS  = 4'h2;       // Read: busy bit
  localparam logic [3:0]  ADDR_LAST    = 4'h3;       // Read: last word
  // Host sequencer states
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_RST   = 3'b001,
    H_REL   = 3'b010,
    H_LOW   = 3'b011,
    H_HIGH  = 3'b100
  } host_state_t;
endpackage : lds_pkg

// ==== core/lds_if.sv ====
// Purpose: Pin bundle between host controller and line driver control.
// Assumes: All pins are one-way logic levels.
// Notes:   Host drives clock, data and reset; boost gates are host side.
interface lds_if;
  logic       ser_clk;          // Serial clock, idles high
  logic       ser_data;         // Serial data, idles high
  logic       dev_rst;          // Active high device reset
  logic [1:0] boost_gate;       // Boost gate pins, channel one in bit 0
  modport host (output ser_clk, output ser_data, output dev_rst,
                output boost_gate);
  modport dev  (input ser_clk, input ser_data, input dev_rst,
                input boost_gate);
endinterface : lds_if

// ==== core/lds_sync.sv ====
// Purpose: Two flop synchroniser for asynchronous inputs.
// Assumes: Input is a slow level.
// Notes:   First stage is read only by the second.
module lds_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;   // First stage
  logic [W-1:0] meta_next;  // First stage next
  logic [W-1:0] q_next;     // Second stage next
  // Next values, frozen while the enable is low
  always_comb begin
    meta_next = ce ? d : meta_reg;
    q_next    = ce ? meta_reg : q;
  end
  // Register both stages
  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q        <= q_next;
  end
endmodule : lds_sync

// ==== core/lds_dev.sv ====
// Purpose: Device end, receives control words and drives channel state.
// Assumes: Pins are asynchronous, sampled by a 50 MHz clock.
// Notes:   Device reset pin acts without waiting for the sampled edge.
//
// How it works
// R1: Data sampled on each link clock rise.
// R2: Host changes data only on falls.
// R3: Host clock period and duty bounded.
// R4: Host holds reset, waits before bits.
// R5: Twelve bits over thirteen clock cycles.
// R6: Clock and data idle high between words.
// R7: Bad framing or parity word discarded.
// R8: Bits two to ten odd parity.
// R9: Select bits load settings per channel.
// R10: Driver bit enables, arm bit arms boost.
// R11: Disabled driver removes bias, floats outputs; code only floats outputs, bias level still follows settings.
// R12: Boost needs arm bit and gate pin.
// R13: Bias level four bits, bit six MSB.
// R14: Gate pin one boosts channel one.
// R15: Reset clears settings and shift register.
// R16: All ones word acts as reset.
// R17: Count from first rise, apply after thirteenth.
module lds_dev (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  lds_if.dev              pins,
  output logic [1:0]      driver_on,       // Line driver enabled
  output logic [1:0]      outputs_hiz,     // Outputs high impedance
  output logic [1:0]      boost_armed,     // Boost supply armed
  output logic [1:0]      boost_active,    // Full boost operation
  output logic [3:0]      bias_level_ch1,  // Channel one bias level
  output logic [3:0]      bias_level_ch2,  // Channel two bias level
  output logic            word_reject      // Pulse: word discarded
);
  // Top bit of the parity span
  localparam int unsigned POS_PAR_HI = lds_pkg::POS_PARITY;
  logic [4:0]  pin_s;          // Synchronised pins
  logic        clk_d_reg;      // Previous sampled link clock
  logic        clk_d_next;
  logic [11:0] shift_reg;      // Bit i holds word bit i
  logic [11:0] shift_next;
  logic [3:0]  cyc_reg;        // Link clock rises counted
  logic [3:0]  cyc_next;
  logic [5:0]  set_reg  [2];   // Channel settings
  logic [5:0]  set_next [2];
  logic        rej_next;
  logic [1:0]  drv_n, arm_n, hiz_n, bst_n;
  logic [3:0]  lvl1_n, lvl2_n;
  logic        rise, dev_rst_s, valid, parity_ok;

  // Pins cross into the system clock domain
  lds_sync #(.W(5)) u_sync (
    .clk (clk),
    .ce  (ce),
    .d   ({pins.boost_gate, pins.dev_rst, pins.ser_data, pins.ser_clk}),
    .q   (pin_s)
  );

  assign rise      = pin_s[0] & ~clk_d_reg;  // R1
  assign dev_rst_s = pin_s[2];
  assign parity_ok = ^shift_reg[POS_PAR_HI:2];  // R8
  assign valid     = shift_reg[lds_pkg::POS_START_HI]
                     & ~shift_reg[lds_pkg::POS_START_LO]
                     & shift_reg[lds_pkg::POS_STOP]
                     & parity_ok;  // R7

  // Receiver and channel settings next state
  always_comb begin
    clk_d_next  = pin_s[0];
    shift_next  = shift_reg;
    cyc_next    = cyc_reg;
    set_next[0] = set_reg[0];
    set_next[1] = set_reg[1];
    rej_next    = 1'b0;
    if (dev_rst_s) begin
      // Reset pin clears shift register, rise count and settings
      shift_next  = lds_pkg::WORD_RST;  // R15
      cyc_next    = 4'h0;
      set_next[0] = lds_pkg::SET_RST;  // R15
      set_next[1] = lds_pkg::SET_RST;
    end else if (rise) begin
      cyc_next = cyc_reg + 4'h1;  // R17
      if (cyc_reg < lds_pkg::BIT_CNT_W) begin
        // Capture next bit in transmission order
        shift_next[cyc_reg] = pin_s[1];  // R1 R5
      end else begin
        // Thirteenth rise completes the word
        cyc_next   = 4'h0;  // R17
        shift_next = lds_pkg::WORD_RST;
        if (shift_reg == lds_pkg::WORD_ALL_ONE) begin
          set_next[0] = lds_pkg::SET_RST;  // R16
          set_next[1] = lds_pkg::SET_RST;
        end else if (valid) begin
          if (shift_reg[lds_pkg::POS_SEL_CH1]) begin
            set_next[0] = shift_reg[9:4];  // R9
          end
          if (shift_reg[lds_pkg::POS_SEL_CH2]) begin
            set_next[1] = shift_reg[9:4];  // R9
          end
        end else begin
          rej_next = 1'b1;  // R7
        end
      end
    end
    // Output decode
    drv_n  = {set_next[1][lds_pkg::SET_DRV], set_next[0][lds_pkg::SET_DRV]};
    arm_n  = {set_next[1][lds_pkg::SET_ARM], set_next[0][lds_pkg::SET_ARM]};
    hiz_n  = ~drv_n;  // R10 R11
    bst_n  = arm_n & pin_s[4:3];  // R12 R14
    // Field bit 2 (word bit 6) is the MSB, so reverse order
    lvl1_n = {set_next[0][2], set_next[0][3], set_next[0][4],
              set_next[0][5]};  // R13
    lvl2_n = {set_next[1][2], set_next[1][3], set_next[1][4],
              set_next[1][5]};  // R13
  end

  // Register receiver, settings and outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_d_reg      <= 1'b1;
      shift_reg      <= lds_pkg::WORD_RST;
      cyc_reg        <= 4'h0;
      set_reg[0]     <= lds_pkg::SET_RST;
      set_reg[1]     <= lds_pkg::SET_RST;
      driver_on      <= 2'h0;
      outputs_hiz    <= 2'h3;
      boost_armed    <= 2'h0;
      boost_active   <= 2'h0;
      bias_level_ch1 <= 4'h0;
      bias_level_ch2 <= 4'h0;
      word_reject    <= 1'b0;
    end else if (ce) begin
      clk_d_reg      <= clk_d_next;
      shift_reg      <= shift_next;
      cyc_reg        <= cyc_next;
      set_reg[0]     <= set_next[0];
      set_reg[1]     <= set_next[1];
      driver_on      <= drv_n;
      outputs_hiz    <= hiz_n;
      boost_armed    <= arm_n;
      boost_active   <= bst_n;
      bias_level_ch1 <= lvl1_n;
      bias_level_ch2 <= lvl2_n;
      word_reject    <= rej_next;
    end
  end
endmodule : lds_dev

// ==== core/lds_host.sv ====
// Purpose: Host end, sends control words and pulses device reset.
// Assumes: 50 MHz clock; link clock made by a divider.
// Notes:   Software port: addr, wdata, wr, rd, rdata one cycle later.
//
// Our own choices: strobed register access and the address map.
module lds_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  lds_if.host              pins,
  input  wire logic [3:0]  addr,        // Register address
  input  wire logic [11:0] wdata,       // Write data
  input  wire logic        wr,          // Write strobe
  input  wire logic        rd,          // Read strobe
  output logic [11:0]      rdata,       // Read data, cycle after rd
  input  wire logic [1:0]  boost_req    // Boost gate requests
);
  lds_pkg::host_state_t st_reg, st_next;  // Sequencer state
  logic [4:0]  tmr_reg, tmr_next;      // Phase timer
  logic [3:0]  bit_reg, bit_next;      // Clock cycle index
  logic [11:0] word_reg, word_next;    // Word being sent
  logic [11:0] last_reg, last_next;    // Last word accepted
  logic [11:0] rdata_next;
  logic        sclk_next, sdat_next, rst_next;
  logic [1:0]  gate_next;
  logic        busy;

  assign busy = (st_reg != lds_pkg::H_IDLE);

  // Sequencer and pin next values
  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg;
    bit_next  = bit_reg;
    word_next = word_reg;
    last_next = last_reg;
    sclk_next = pins.ser_clk;
    sdat_next = pins.ser_data;
    rst_next  = pins.dev_rst;
    gate_next = boost_req;  // R14
    case (st_reg)
      lds_pkg::H_IDLE: begin
        sclk_next = 1'b1;  // R6
        sdat_next = 1'b1;  // R6
        if (wr && addr == lds_pkg::ADDR_CMD) begin
          // Odd parity over bits 2..10 is forced into bit 10
          word_next     = wdata;
          word_next[10] = ~^wdata[9:2];  // R8
          last_next     = word_next;
          bit_next      = 4'h0;
          tmr_next      = 5'(lds_pkg::HALF_CYC - 1);
          st_next       = lds_pkg::H_LOW;
          sclk_next     = 1'b0;  // R2
          sdat_next     = wdata[0];
        end else if (wr && addr == lds_pkg::ADDR_RESET) begin
          rst_next = 1'b1;
          tmr_next = 5'(lds_pkg::RST_HOLD_CYC - 1);  // R4
          st_next  = lds_pkg::H_RST;
        end
      end
      lds_pkg::H_RST: begin
        if (tmr_reg == 5'h0) begin
          rst_next = 1'b0;
          tmr_next = 5'(lds_pkg::RST_REL_CYC - 1);  // R4
          st_next  = lds_pkg::H_REL;
        end else begin
          tmr_next = tmr_reg - 5'h1;
        end
      end
      lds_pkg::H_REL: begin
        if (tmr_reg == 5'h0) begin
          st_next = lds_pkg::H_IDLE;
        end else begin
          tmr_next = tmr_reg - 5'h1;
        end
      end
      lds_pkg::H_LOW: begin
        if (tmr_reg == 5'h0) begin
          sclk_next = 1'b1;  // R3
          tmr_next  = 5'(lds_pkg::HALF_CYC - 1);
          st_next   = lds_pkg::H_HIGH;
        end else begin
          tmr_next = tmr_reg - 5'h1;
        end
      end
      lds_pkg::H_HIGH: begin
        if (tmr_reg != 5'h0) begin
          tmr_next = tmr_reg - 5'h1;
        end else if (bit_reg == lds_pkg::BIT_CNT_W) begin
          st_next = lds_pkg::H_IDLE;  // R5 R6
        end else begin
          // Data changes only together with the falling edge
          bit_next  = bit_reg + 4'h1;
          sclk_next = 1'b0;  // R2
          sdat_next = (bit_reg == 4'hb) ? 1'b1 : word_reg[bit_reg + 4'h1];
          tmr_next  = 5'(lds_pkg::HALF_CYC - 1);
          st_next   = lds_pkg::H_LOW;
        end
      end
      default: st_next = lds_pkg::H_IDLE;
    endcase
    // Register read port
    if (rd && addr == lds_pkg::ADDR_STATUS) begin
      rdata_next = {11'h000, busy};
    end else if (rd && addr == lds_pkg::ADDR_LAST) begin
      rdata_next = last_reg;
    end else begin
      rdata_next = 12'h000;
    end
  end

  // Register sequencer and pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg          <= lds_pkg::H_IDLE;
      tmr_reg         <= 5'h0;
      bit_reg         <= 4'h0;
      word_reg        <= 12'h000;
      last_reg        <= 12'h000;
      rdata           <= 12'h000;
      pins.ser_clk    <= 1'b1;
      pins.ser_data   <= 1'b1;
      pins.dev_rst    <= 1'b0;
      pins.boost_gate <= 2'h0;
    end else if (ce) begin
      st_reg          <= st_next;
      tmr_reg         <= tmr_next;
      bit_reg         <= bit_next;
      word_reg        <= word_next;
      last_reg        <= last_next;
      rdata           <= rdata_next;
      pins.ser_clk    <= sclk_next;
      pins.ser_data   <= sdat_next;
      pins.dev_rst    <= rst_next;
      pins.boost_gate <= gate_next;
    end
  end
endmodule : lds_host

// ==== bench/lds_assertions.sv ====
// Purpose: Concurrent checks on the host to device serial link.
// Assumes: One clock domain, synchronous active high reset.
// Notes:   Counters time link clock phases and settings updates.
module lds_check (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ser_clk,
  input wire logic       ser_data,
  input wire logic       dev_rst,
  input wire logic [1:0] boost_gate,
  input wire logic [1:0] driver_on,
  input wire logic [1:0] outputs_hiz,
  input wire logic [1:0] boost_armed,
  input wire logic [1:0] boost_active,
  input wire logic [3:0] bias_level_ch1,
  input wire logic [3:0] bias_level_ch2,
  input wire logic       word_reject
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0]  lo_reg, lo_next;  // Link clock low samples
  logic [7:0]  rh_reg, rh_next;  // Device reset high samples
  logic [7:0]  ev_reg, ev_next;  // Samples since link rise or reset
  logic        sc_reg;           // Link clock one sample ago
  logic [11:0] set_w;            // All stored settings outputs
  assign set_w = {driver_on, boost_armed, bias_level_ch1, bias_level_ch2};
  // The event counter saturates so idle stretches cannot wrap it
  always_comb begin
    lo_next = ser_clk ? 8'h00 : lo_reg + 8'h01;
    rh_next = dev_rst ? rh_reg + 8'h01 : 8'h00;
    ev_next = (ev_reg == 8'hff) ? ev_reg : ev_reg + 8'h01;
    if ((ser_clk && !sc_reg) || dev_rst) begin
      ev_next = 8'h00;
    end
  end
  // Counter registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lo_reg <= 8'h00;
      rh_reg <= 8'h00;
      ev_reg <= 8'hff;
      sc_reg <= 1'b1;
    end else begin
      lo_reg <= lo_next;
      rh_reg <= rh_next;
      ev_reg <= ev_next;
      sc_reg <= ser_clk;
    end
  end
  a_hiz_tracks_drv: assert property (outputs_hiz == ~driver_on)
    else $error("outputs float state disagrees with driver state");
  a_boost_gated: assert property ((boost_active & ~boost_armed) == 2'b00)
    else $error("boost active without arm bit");
  a_boost_ch1_on: assert property ((boost_armed[0] && boost_gate[0])[*6]
    |-> boost_active[0]) else $error("channel one boost not active");
  a_boost_ch2_on: assert property ((boost_armed[1] && boost_gate[1])[*6]
    |-> boost_active[1]) else $error("channel two boost not active");
  a_low_phase: assert property ($rose(ser_clk) |-> lo_reg >= 8'h12
    && lo_reg <= 8'h1c) else $error("link clock low phase out of range");
  a_data_on_fall: assert property ($changed(ser_data) |-> $fell(ser_clk))
    else $error("data changed away from a clock fall");
  a_rst_hold: assert property ($fell(dev_rst) |-> rh_reg >= 8'h14)
    else $error("device reset pulse too short");
  a_rst_release: assert property ($fell(dev_rst) |-> ser_clk[*8]
    ##1 ser_clk[*2]) else $error("clock fell too soon after reset");
  a_rst_clears: assert property ($rose(dev_rst) |-> ##[1:6]
    set_w == 12'h000) else $error("device reset left settings");
  a_change_after_word: assert property ($changed(set_w)
    |-> ev_reg <= 8'h0c) else $error("settings changed outside a word");
  a_reject_keeps: assert property (word_reject |=> !word_reject
    && $stable(set_w)) else $error("rejected word had an effect");
endmodule : lds_check

// ==== bench/line_driver_serial_control_test.sv ====
// Purpose: Self-checking bench, host and device joined by one link.
// Assumes: 50 MHz clock, synchronous reset held 16 cycles.
// Notes:   A second device is driven by hand to send bad parity.
module line_driver_serial_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, ce, wr, rd;    // Clock, reset, strobes
  logic [3:0]  addr;                        // Register address
  logic [11:0] wdata, rdata, w, s;          // Bus data and scratch
  logic [1:0]  boost_req, drv, hiz, arm, act, b_drv; // Levels
  logic [3:0]  bias1, bias2, b_bias;        // Bias levels
  logic        rej, b_rej;                  // Reject pulses
  logic [5:0]  e1, e2;                      // Expected settings
  int          mismatches, n_tests, rej_n, b_rej_n, cyc, seed, r;
  int          pos[3] = '{0, 1, 11};        // Framing bit positions
  lds_if if_a ();
  lds_if if_b ();
  lds_host i_lds_host (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .pins(if_a.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .boost_req(boost_req));
  lds_dev i_lds_dev (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .pins(if_a.dev), .driver_on(drv), .outputs_hiz(hiz),
    .boost_armed(arm), .boost_active(act), .bias_level_ch1(bias1),
    .bias_level_ch2(bias2), .word_reject(rej));
  lds_dev i_lds_dev_b (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .pins(if_b.dev), .driver_on(b_drv), .outputs_hiz(),
    .boost_armed(), .boost_active(), .bias_level_ch1(b_bias),
    .bias_level_ch2(), .word_reject(b_rej));
  lds_check i_lds_check (.clk(clk), .sys_rst(sys_rst),
    .ser_clk(if_a.ser_clk), .ser_data(if_a.ser_data),
    .dev_rst(if_a.dev_rst), .boost_gate(if_a.boost_gate),
    .driver_on(drv), .outputs_hiz(hiz), .boost_armed(arm),
    .boost_active(act), .bias_level_ch1(bias1),
    .bias_level_ch2(bias2), .word_reject(rej));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Final verdict, reached from the main flow or the timeout
  task tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Cycle count, reject pulse counts and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rej === 1'b1) rej_n <= rej_n + 1;
    if (b_rej === 1'b1) b_rej_n <= b_rej_n + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  // Builds a well framed word with odd parity over bits two to ten
  function automatic logic [11:0] mk(input logic [1:0] sel,
                                     input logic [5:0] st);
    mk = {1'b1, ~^{st, sel}, st, sel, 2'b01};
  endfunction : mk
  // Single compare for every kind of value
  task chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
    n_tests++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One cycle write strobe
  task bus_wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // One cycle read strobe, data taken in the following cycle
  task bus_rd(input logic [3:0] a, output logic [11:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // Polls the busy bit under a bound
  task wait_idle();
    logic [11:0] st;
    int n;
    st = 12'h001;
    n = 0;
    while (st[0] !== 1'b0 && n < 2000) begin
      bus_rd(lds_pkg::ADDR_STATUS, st);
      n++;
    end
    chk("busy", 12'h000, st & 12'h001);
  endtask : wait_idle
  // Compares every settings output against the model
  task check_state();
    #1;
    chk("drv", 12'({e2[0], e1[0]}), 12'(drv));
    chk("hiz", 12'({~e2[0], ~e1[0]}), 12'(hiz));
    chk("arm", 12'({e2[1], e1[1]}), 12'(arm));
    chk("act", 12'({e2[1], e1[1]} & boost_req), 12'(act));
    chk("bias1", 12'({e1[2], e1[3], e1[4], e1[5]}), 12'(bias1));
    chk("bias2", 12'({e2[2], e2[3], e2[4], e2[5]}), 12'(bias2));
  endtask : check_state
  // Sends one word through the host and updates the model
  task send(input logic [11:0] wd);
    logic [11:0] lw;
    logic ok;
    int r0;
    lw = wd;
    lw[10] = ~^wd[9:2];
    ok = lw[0] && !lw[1] && lw[11];
    r0 = rej_n;
    bus_wr(lds_pkg::ADDR_CMD, wd);
    wait_idle();
    repeat (12) @(posedge clk);
    if (lw == 12'hfff) begin
      e1 = 6'h00;
      e2 = 6'h00;
    end else if (ok) begin
      if (lw[2]) e1 = lw[9:4];
      if (lw[3]) e2 = lw[9:4];
    end
    if (lw != 12'hfff) chk("reject", 12'(!ok), 12'(rej_n - r0));
    bus_rd(lds_pkg::ADDR_LAST, s);
    chk("last", lw, s);
    check_state();
    @(posedge clk) boost_req <= ~boost_req;
    repeat (8) @(posedge clk);
    check_state();
  endtask : send
  // Drives the second link by hand, data set on each fall
  task bang(input logic [11:0] wd);
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      if_b.ser_clk <= 1'b0;
      if_b.ser_data <= (i < 12) ? wd[i] : 1'b1;
      repeat (23) @(posedge clk);
      if_b.ser_clk <= 1'b1;
      repeat (22) @(posedge clk);
    end
  endtask : bang
  // Holds system reset for sixteen cycles
  task do_reset();
    @(posedge clk) sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    e1 = 6'h00;
    e2 = 6'h00;
    @(posedge clk);
  endtask : do_reset
  // Main sequence
  initial begin
    {seed, mismatches, n_tests, rej_n, b_rej_n, cyc} = '0;
    seed = 61;
    {ce, sys_rst, wr, rd, addr, wdata, boost_req} = '0;
    ce = 1'b1;
    sys_rst = 1'b1;
    {if_b.ser_clk, if_b.ser_data, if_b.dev_rst, if_b.boost_gate} = 5'h18;
    do_reset();
    check_state();
    send(mk(2'b11, 6'h3f));
    send(mk(2'b01, 6'h05));
    for (int i = 0; i < 3; i++) begin
      w = mk(2'b11, 6'h00);
      w[pos[i]] = ~w[pos[i]];
      send(w);
    end
    send(12'hfff);
    bus_wr(lds_pkg::ADDR_CMD, mk(2'b10, 6'h2a));
    bus_wr(lds_pkg::ADDR_CMD, 12'hfff);
    wait_idle();
    repeat (12) @(posedge clk);
    e2 = 6'h2a;
    bus_rd(lds_pkg::ADDR_LAST, s);
    chk("refused", mk(2'b10, 6'h2a), s);
    check_state();
    repeat (20) begin
      r = $random(seed);
      w = mk(r[1:0], r[7:2]);
      w[10] = r[11];
      if (r[10:8] == 3'h0) w[1] = 1'b1;
      send(w);
    end
    bus_wr(lds_pkg::ADDR_RESET, 12'h000);
    wait_idle();
    repeat (40) @(posedge clk);
    e1 = 6'h00;
    e2 = 6'h00;
    check_state();
    bus_rd(4'h7, s);
    chk("unmapped", 12'h000, s);
    bang(mk(2'b01, 6'h3d));
    bang(mk(2'b01, 6'h3d) ^ 12'h400);
    repeat (12) @(posedge clk);
    #1 chk("b_drv", 12'h001, 12'(b_drv));
    chk("b_bias", 12'h00f, 12'(b_bias));
    chk("b_rej", 12'h001, 12'(b_rej_n));
    do_reset();
    check_state();
    tally_and_finish();
  end
endmodule : line_driver_serial_control_test
